//--- i2cms_params.svh
`ifndef I2CMS_PARAMS_SVH
`define I2CMS_PARAMS_SVH

// Register byte offsets
`define I2CMS_OFS_CTRL 5'h00
`define I2CMS_OFS_OWNADDR 5'h04
`define I2CMS_OFS_STATUS 5'h08
`define I2CMS_OFS_MASK 5'h0c
`define I2CMS_OFS_CONFIG 5'h10

// Control register field positions
`define I2CMS_BIT_MST 5
`define I2CMS_BIT_TRS 4
`define I2CMS_BIT_RATE_SELECT_TOP 3

// Status and mask field positions
`define I2CMS_BIT_ARBLOST 0
`define I2CMS_BIT_ADDRMATCH 1
`define I2CMS_BIT_OVERRUN 2

// Config register field positions
`define I2CMS_BIT_SYNCFMT 0

// Reset values
`define I2CMS_RST_CTRL 8'h00
`define I2CMS_RST_OWNADDR 7'h00
`define I2CMS_RST_MASK 3'h0
`define I2CMS_RST_CONFIG 1'b0

// Data setup hold in system cycles
`define I2CMS_SETUP_CYC_LO 10
`define I2CMS_SETUP_CYC_HI 20

// Cycles from clock release until the synchronised level shows it high
`define I2CMS_STRETCH_LAG 6

// Division ratios, top rate-select bit low
`define I2CMS_DIV_0_0 28
`define I2CMS_DIV_0_1 40
`define I2CMS_DIV_0_2 48
`define I2CMS_DIV_0_3 64
`define I2CMS_DIV_0_4 168
`define I2CMS_DIV_0_5 100
`define I2CMS_DIV_0_6 112
`define I2CMS_DIV_0_7 128

// Division ratios, top rate-select bit high
`define I2CMS_DIV_1_0 56
`define I2CMS_DIV_1_1 80
`define I2CMS_DIV_1_2 96
`define I2CMS_DIV_1_3 128
`define I2CMS_DIV_1_4 336
`define I2CMS_DIV_1_5 200
`define I2CMS_DIV_1_6 224
`define I2CMS_DIV_1_7 256

`endif

//--- i2cms_pkg.sv
package i2cms_pkg;
	typedef enum logic [1:0] {
		I2CMS_SLAVE_RX = 2'h0,
		I2CMS_SLAVE_TX = 2'h1,
		I2CMS_MASTER_RX = 2'h2,
		I2CMS_MASTER_TX = 2'h3
	} i2cms_mode_type;

	typedef enum logic [1:0] {
		I2CMS_DIV_IDLE,
		I2CMS_DIV_LOW,
		I2CMS_DIV_HIGH
	} i2cms_div_state_type;
endpackage

//--- i2cms_rate_div.sv
`timescale 1ns/1ns
`include "i2cms_params.svh"
module i2cms_rate_div (
	input wire logic mclk,
	input wire logic rst,
	input wire logic enable,
	input wire logic [3:0] rate_sel,
	input wire logic scl_level,
	output logic scl_low,
	output logic period_tick
);
	i2cms_pkg::i2cms_div_state_type state_q;
	logic [8:0] cnt_q;
	logic [8:0] ratio;
	logic [8:0] half;

	function automatic logic [8:0] div_ratio(input logic [3:0] sel);
		case (sel)
			4'h0: div_ratio = 9'(`I2CMS_DIV_0_0);
			4'h1: div_ratio = 9'(`I2CMS_DIV_0_1);
			4'h2: div_ratio = 9'(`I2CMS_DIV_0_2);
			4'h3: div_ratio = 9'(`I2CMS_DIV_0_3);
			4'h4: div_ratio = 9'(`I2CMS_DIV_0_4);
			4'h5: div_ratio = 9'(`I2CMS_DIV_0_5);
			4'h6: div_ratio = 9'(`I2CMS_DIV_0_6);
			4'h7: div_ratio = 9'(`I2CMS_DIV_0_7);
			4'h8: div_ratio = 9'(`I2CMS_DIV_1_0);
			4'h9: div_ratio = 9'(`I2CMS_DIV_1_1);
			4'ha: div_ratio = 9'(`I2CMS_DIV_1_2);
			4'hb: div_ratio = 9'(`I2CMS_DIV_1_3);
			4'hc: div_ratio = 9'(`I2CMS_DIV_1_4);
			4'hd: div_ratio = 9'(`I2CMS_DIV_1_5);
			4'he: div_ratio = 9'(`I2CMS_DIV_1_6);
			default: div_ratio = 9'(`I2CMS_DIV_1_7);
		endcase
	endfunction

	assign ratio = div_ratio(rate_sel);
	assign half = {1'b0, ratio[8:1]};

	// Low half, then high half; high half waits while the bus holds clock low
	always_ff @(posedge mclk) begin
		period_tick <= 1'b0;
		if (rst || !enable) begin
			state_q <= i2cms_pkg::I2CMS_DIV_IDLE;
			cnt_q <= 9'h000;
			scl_low <= 1'b0;
		end else begin
			case (state_q)
				i2cms_pkg::I2CMS_DIV_IDLE: begin
					state_q <= i2cms_pkg::I2CMS_DIV_LOW;
					cnt_q <= 9'h001;
					scl_low <= 1'b1;
				end
				i2cms_pkg::I2CMS_DIV_LOW: begin
					if (cnt_q >= half) begin
						state_q <= i2cms_pkg::I2CMS_DIV_HIGH;
						scl_low <= 1'b0;
					end
					cnt_q <= cnt_q + 9'h001;
				end
				i2cms_pkg::I2CMS_DIV_HIGH: begin
					if (cnt_q > half + 9'(`I2CMS_STRETCH_LAG) && !scl_level) begin
						cnt_q <= cnt_q;
					end else if (cnt_q >= ratio) begin
						state_q <= i2cms_pkg::I2CMS_DIV_LOW;
						cnt_q <= 9'h001;
						scl_low <= 1'b1;
						period_tick <= 1'b1;
					end else begin
						cnt_q <= cnt_q + 9'h001;
					end
				end
				default: begin
					state_q <= i2cms_pkg::I2CMS_DIV_IDLE;
					scl_low <= 1'b0;
				end
			endcase
		end
	end
endmodule

//--- i2cms_setup_hold.sv
`timescale 1ns/1ns
`include "i2cms_params.svh"
module i2cms_setup_hold (
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire logic long_hold,
	output logic busy
);
	localparam logic [4:0] CYC_LO = 5'(`I2CMS_SETUP_CYC_LO);
	localparam logic [4:0] CYC_HI = 5'(`I2CMS_SETUP_CYC_HI);
	logic [4:0] cnt_q;

	// Holds busy for exactly the selected number of cycles
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= 5'h00;
			busy <= 1'b0;
		end else if (start) begin
			cnt_q <= (long_hold ? CYC_HI : CYC_LO) - 5'h01;
			busy <= 1'b1;
		end else if (cnt_q != 5'h00) begin
			cnt_q <= cnt_q - 5'h01;
		end else begin
			busy <= 1'b0;
		end
	end
endmodule

//--- i2cms_top.sv
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "i2cms_params.svh"
// What this block does
// - Arbitration loss outside synchronous format clears master and transmit bits
// - Own address with read bit, as slave receiver outside synchronous format, sets transmit
// - Synchronous-format overrun as master clears master
// - Synchronous format drives clock only as master
// - Master and transmit bits encode four modes
// - Slave transmit setup hold 10 or 20
// - Top bit low: divide by 28..168
// - Top bit high: divide by 56..336
// - Reset clears direction and rate bits
module i2cms_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	input wire logic arb_lost,
	input wire logic overrun_err,
	input wire logic addr_byte_valid,
	input wire logic [7:0] addr_byte,
	input wire logic scl_in,
	output logic scl_o,
	output logic scl_oe,
	output logic [1:0] mode,
	output logic rate_tick
);
	logic mst_q;
	logic trs_q;
	logic [3:0] cks_q;
	logic [1:0] ctrl_hi_q;
	logic [6:0] own_addr_q;
	logic [2:0] status_q;
	logic [2:0] status_d;
	logic [2:0] mask_q;
	logic sync_fmt_q;
	logic [31:0] rdata_d;
	logic wr_take;
	logic wr_lo;
	logic scl_meta_q;
	logic scl_s2_q;
	logic scl_s3_q;
	logic scl_level_q;
	logic scl_fall;
	logic div_low;
	logic hold_busy;
	logic addr_hit;
	logic arb_hit;
	logic ovr_hit;
	logic setup_start;

	// Bus slave: one wait cycle, then the access completes
	assign wr_take = avs_write && !avs_waitrequest;
	assign wr_lo = wr_take && avs_byteenable[0];

	always_ff @(posedge mclk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		case (avs_address)
			`I2CMS_OFS_CTRL: rdata_d[7:0] = {ctrl_hi_q, mst_q, trs_q, cks_q};
			`I2CMS_OFS_OWNADDR: rdata_d[7:0] = {own_addr_q, 1'b0};
			`I2CMS_OFS_STATUS: rdata_d[2:0] = status_q;
			`I2CMS_OFS_MASK: rdata_d[2:0] = mask_q;
			`I2CMS_OFS_CONFIG: rdata_d[2:0] = {hold_busy, div_low, sync_fmt_q};
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rdata_d;
		end
	end

	// Hardware events qualified by mode and format
	assign arb_hit = arb_lost && mst_q && !sync_fmt_q;
	assign ovr_hit = overrun_err && mst_q && sync_fmt_q;
	assign addr_hit = addr_byte_valid && !mst_q && !trs_q && !sync_fmt_q &&
		(addr_byte[7:1] == own_addr_q) && addr_byte[0];

	// Master select: hardware clears win over a software write
	always_ff @(posedge mclk) begin
		if (rst) begin
			mst_q <= 1'(`I2CMS_RST_CTRL >> `I2CMS_BIT_MST);
		end else if (arb_hit) begin
			mst_q <= 1'b0;
		end else if (ovr_hit) begin
			mst_q <= 1'b0;
		end else if (wr_lo && avs_address == `I2CMS_OFS_CTRL) begin
			mst_q <= avs_writedata[`I2CMS_BIT_MST];
		end
	end

	// Transmit direction; software is expected to write it between frames
	always_ff @(posedge mclk) begin
		if (rst) begin
			trs_q <= 1'b0;
		end else if (arb_hit) begin
			trs_q <= 1'b0;
		end else if (addr_hit) begin
			trs_q <= 1'b1;
		end else if (wr_lo && avs_address == `I2CMS_OFS_CTRL) begin
			trs_q <= avs_writedata[`I2CMS_BIT_TRS];
		end
	end

	// Rate select and spare control bits
	always_ff @(posedge mclk) begin
		if (rst) begin
			cks_q <= 4'h0;
			ctrl_hi_q <= 2'h0;
		end else if (wr_lo && avs_address == `I2CMS_OFS_CTRL) begin
			cks_q <= avs_writedata[3:0];
			ctrl_hi_q <= avs_writedata[7:6];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			own_addr_q <= `I2CMS_RST_OWNADDR;
			mask_q <= `I2CMS_RST_MASK;
			sync_fmt_q <= `I2CMS_RST_CONFIG;
		end else if (wr_lo) begin
			if (avs_address == `I2CMS_OFS_OWNADDR) begin
				own_addr_q <= avs_writedata[7:1];
			end
			if (avs_address == `I2CMS_OFS_MASK) begin
				mask_q <= avs_writedata[2:0];
			end
			if (avs_address == `I2CMS_OFS_CONFIG) begin
				sync_fmt_q <= avs_writedata[`I2CMS_BIT_SYNCFMT];
			end
		end
	end

	// Sticky status, write one to clear, a new event wins
	always_comb begin
		status_d = status_q;
		if (wr_lo && avs_address == `I2CMS_OFS_STATUS) begin
			status_d = status_q & ~avs_writedata[2:0];
		end
		if (arb_hit) begin
			status_d[`I2CMS_BIT_ARBLOST] = 1'b1;
		end
		if (addr_hit) begin
			status_d[`I2CMS_BIT_ADDRMATCH] = 1'b1;
		end
		if (ovr_hit) begin
			status_d[`I2CMS_BIT_OVERRUN] = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			status_q <= 3'h0;
		end else begin
			status_q <= status_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_q & mask_q);
		end
	end

	// Clock pin synchroniser; level moves once stages two and three agree
	always_ff @(posedge mclk) begin
		if (rst) begin
			scl_meta_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			scl_level_q <= 1'b1;
		end else begin
			scl_meta_q <= scl_in;
			scl_s2_q <= scl_meta_q;
			scl_s3_q <= scl_s2_q;
			if (scl_s2_q == scl_s3_q) begin
				scl_level_q <= scl_s3_q;
			end
		end
	end

	assign scl_fall = scl_level_q && (scl_s2_q == scl_s3_q) && !scl_s3_q;
	assign setup_start = scl_fall && !mst_q && trs_q;

	i2cms_rate_div u_div (
		.mclk(mclk),
		.rst(rst),
		.enable(mst_q),
		.rate_sel(cks_q),
		.scl_level(scl_level_q),
		.scl_low(div_low),
		.period_tick(rate_tick)
	);

	i2cms_setup_hold u_hold (
		.mclk(mclk),
		.rst(rst),
		.start(setup_start),
		.long_hold(cks_q[`I2CMS_BIT_RATE_SELECT_TOP]),
		.busy(hold_busy)
	);

	// Clock pin drive: master phases, or slave setup hold
	always_ff @(posedge mclk) begin
		if (rst) begin
			scl_o <= 1'b0;
			scl_oe <= 1'b0;
		end else begin
			scl_o <= 1'b0;
			if (mst_q) begin
				scl_oe <= div_low;
			end else begin
				scl_oe <= (setup_start || hold_busy) && trs_q && !sync_fmt_q;
			end
		end
	end

	assign mode = {mst_q, trs_q};
endmodule

//--- i2cms_end.sv
`timescale 1ns/1ns

//--- i2cms_asserts.sv
`timescale 1ns/1ns
module i2cms_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	input wire logic irq,
	input wire logic arb_lost,
	input wire logic overrun_err,
	input wire logic addr_byte_valid,
	input wire logic [7:0] addr_byte,
	input wire logic scl_oe,
	input wire logic [1:0] mode,
	input wire logic rate_tick
);
	int dv[16] = '{28, 40, 48, 64, 168, 100, 112, 128, 56, 80, 96, 128, 336, 200, 224, 256};
	logic wr;
	logic sync_q;
	logic [3:0] rs_q;
	logic [9:0] cnt_q;
	logic [9:0] hi_q;
	assign wr = avs_write && !avs_waitrequest;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Shadow of format and rate fields
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync_q <= 1'h0;
			rs_q <= 4'h0;
		end else if (wr && avs_address == 5'h10) begin
			sync_q <= avs_writedata[0];
		end else if (wr && avs_address == 5'h00) begin
			rs_q <= avs_writedata[3:0];
		end
	end
	always_ff @(posedge mclk) begin
		cnt_q <= (rate_tick || !mode[1]) ? 10'h000 : cnt_q + 10'h001;
		hi_q <= scl_oe ? hi_q + 10'h001 : 10'h000;
	end
	arb_clear_a: assert property (arb_lost && mode[1] && !sync_q |=> mode == 2'h0)
		else $error("arb loss kept master");
	ovr_clear_a: assert property (overrun_err && mode[1] && sync_q |=> !mode[1])
		else $error("overrun kept master");
	trs_cause_a: assert property ($rose(mode[0]) |-> $past(wr || addr_byte_valid && addr_byte[0]))
		else $error("direction set without cause");
	sync_drv_a: assert property ((sync_q && !mode[1]) [*3] |-> !scl_oe)
		else $error("sync slave drives clock");
	rx_quiet_a: assert property ((mode == 2'h0) [*3] |-> !scl_oe)
		else $error("slave receive drives clock");
	rst_val_a: assert property ($past(rst) |-> mode == 2'h0 && !scl_oe && !irq && !rate_tick)
		else $error("bad reset state");
	tick_min_a: assert property (rate_tick |-> cnt_q >= dv[rs_q] - 1)
		else $error("clock period short");
	hold_len_a: assert property ($fell(scl_oe) && $past(mode) == 2'h1 && !sync_q |-> hi_q - (rs_q[3] ? 20 : 10) < 2)
		else $error("setup hold length wrong");
	cover property (arb_lost && mode[1]);
	cover property (rate_tick && mode[1]);
	cover property ($fell(scl_oe) && mode == 2'h1);
endmodule
bind i2cms_top i2cms_chk u_i2cms_chk (.mclk, .rst, .avs_address, .avs_write, .avs_writedata,
	.avs_waitrequest, .irq, .arb_lost, .overrun_err, .addr_byte_valid, .addr_byte, .scl_oe,
	.mode, .rate_tick);

//--- i2cms_peer.sv
`timescale 1ns/1ns
module i2cms_peer (
	input wire logic mclk,
	input wire logic scl_oe,
	input wire logic hold_low,
	input wire logic run_clk,
	output logic scl_in
);
	logic [4:0] ph_q = 5'h00;
	// Remote master clock, still when idle
	always_ff @(posedge mclk) begin
		ph_q <= run_clk ? ph_q + 5'h01 : 5'h00;
	end
	// Open-drain wire with pull-up
	assign scl_in = !(scl_oe || hold_low || ph_q[4]);
endmodule

//--- i2cms_top_test.sv
`timescale 1ns/1ns
module i2cms_top_test;
	logic mclk = 1'h0;
	logic rst = 1'h1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h1;
	logic scl_o;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	logic arb_lost = 1'h0;
	logic overrun_err = 1'h0;
	logic addr_byte_valid = 1'h0;
	logic [7:0] addr_byte = 8'h00;
	logic scl_in;
	logic scl_oe;
	logic [1:0] mode;
	logic rate_tick;
	logic hold = 1'h0;
	logic run = 1'h0;
	logic [31:0] rd;
	int fail_count = 0;
	int tests_run = 0;
	int seed = 32'h3895;
	int cyc = 0;
	int ctl = 0;
	int st = 0;
	int msk = 0;
	int cfg = 0;
	int own = 0;
	int p;
	int dv[$] = {28, 40, 48, 64, 168, 100, 112, 128, 56, 80, 96, 128, 336, 200, 224, 256};
	i2cms_top u_i2cms_top (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .arb_lost, .overrun_err,
		.addr_byte_valid, .addr_byte, .scl_in, .scl_o, .scl_oe, .mode, .rate_tick);
	i2cms_peer u_i2cms_peer (.mclk, .scl_oe, .hold_low(hold), .run_clk(run), .scl_in);
	always #4 mclk = !mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 20000) begin
			fail_count++;
			complete_run();
		end
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (e !== g) begin
			fail_count++;
			$display("[FAIL] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic bus(input logic w, input int a, input int d);
		@(posedge mclk);
		avs_address <= 5'(a);
		avs_writedata <= 32'(d);
		avs_write <= w;
		avs_read <= !w;
		@(posedge mclk);
		while (avs_waitrequest !== 1'h0) begin
			@(posedge mclk);
		end
		rd = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask
	task automatic wr(input int a, input int d);
		case (a)
			0: ctl = d;
			4: own = d >> 1;
			8: st = st & ~d;
			12: msk = d;
			16: cfg = d;
		endcase
		bus(1'h1, a, d);
	endtask
	task automatic rdc(input int a, input int e);
		bus(1'h0, a, 0);
		chk(e, rd);
	endtask
	task automatic obs;
		repeat (2) @(posedge mclk);
		#1;
		chk(ctl >> 4 & 3, mode);
		chk((st & msk) != 0, irq);
		chk(0, scl_o);
	endtask
	task automatic ev(input int k, input int b);
		@(posedge mclk);
		arb_lost <= k == 0;
		overrun_err <= k == 1;
		addr_byte_valid <= k == 2;
		addr_byte <= 8'(b);
		@(posedge mclk);
		arb_lost <= 1'h0;
		overrun_err <= 1'h0;
		addr_byte_valid <= 1'h0;
		if (k == 0 && ctl[5] && cfg == 0) begin
			ctl = ctl & 32'hcf;
			st = st | 1;
		end
		if (k == 1 && ctl[5] && cfg == 1) begin
			ctl = ctl & 32'hdf;
			st = st | 4;
		end
		if (k == 2 && ctl[5:4] == 0 && cfg == 0 && b == (own << 1 | 1)) begin
			ctl = ctl | 32'h10;
			st = st | 2;
		end
		obs();
	endtask
	task automatic per(input int h);
		while (rate_tick !== 1'h1) begin
			@(posedge mclk);
		end
		hold <= h > 0;
		p = 1;
		@(posedge mclk);
		while (rate_tick !== 1'h1 && p < 1000) begin
			@(posedge mclk);
			p++;
			if (p == h) hold <= 1'h0;
		end
	endtask
	task automatic frame(input int e);
		int r;
		int m;
		r = 0;
		m = 0;
		run <= 1'h1;
		repeat (100) begin
			@(posedge mclk);
			r = (scl_oe === 1'h1) ? r + 1 : 0;
			if (r > m) begin
				m = r;
			end
		end
		run <= 1'h0;
		chk(e, m);
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 1'h0;
		for (int a = 0; a < 24; a += 4) rdc(a, 0);
		for (int k = 0; k < 16; k++) begin
			wr(0, 32'h20 + k);
			rdc(0, ctl);
			per(0);
			chk(dv[k], p);
			obs();
			wr(0, k);
		end
		wr(0, 32'h20);
		per(60);
		chk(1, p > 60);
		wr(0, 32'h30);
		obs();
		ev(0, 0);
		wr(12, 7);
		obs();
		avs_byteenable <= 4'he;
		bus(1'h1, 12, 0);
		avs_byteenable <= 4'h1;
		rdc(12, msk);
		rdc(8, st);
		wr(8, 1);
		obs();
		wr(16, 1);
		wr(0, 32'h30);
		ev(0, 0);
		wr(0, 32'h20);
		per(0);
		chk(dv[0], p);
		ev(1, 0);
		frame(0);
		wr(16, 0);
		p = $random(seed) & 32'h7f;
		wr(4, p << 1);
		ev(2, (own ^ 1) << 1 | 1);
		ev(2, own << 1);
		ev(2, own << 1 | 1);
		frame((ctl[3] ? 20 : 10) + 1);
		wr(0, 32'h18);
		frame((ctl[3] ? 20 : 10) + 1);
		rdc(8, st);
		complete_run();
	end
endmodule
